// File: common/iocs_pkg.sv
// Constants, field layout, state encoding and timing counts for the internal oscillator clock switch.
// Assumes one system clock at the rate of CLK_KHZ; all oscillator waveforms are modelled as levels on it.
package iocs_pkg;

  // ****************************************************************
  // Clock rate and oscillator figures
  // ****************************************************************
  localparam int CLK_KHZ      = 250000;
  localparam int HF_KHZ       = 16000;
  localparam int MF_KHZ       = 500;
  localparam int LF_KHZ       = 31;
  localparam int PLL_KHZ      = 32000;
  localparam int HF_START_NS  = 2000;
  localparam int MF_START_NS  = 2000;
  localparam int LF_START_NS  = 2000;
  localparam int PLL_LOCK_US  = 2000;

  localparam logic [15:0] HF_HALF  = 16'(CLK_KHZ / (2 * HF_KHZ));
  localparam logic [15:0] MF_HALF  = 16'(CLK_KHZ / (2 * MF_KHZ));
  localparam logic [15:0] LF_HALF  = 16'(CLK_KHZ / (2 * LF_KHZ));
  localparam logic [15:0] PLL_HALF = 16'(CLK_KHZ / (2 * PLL_KHZ));
  localparam logic [15:0] EXT_HALF = 16'h0001;

  // Least times round up to whole cycles.
  localparam logic [19:0] HF_START_CYC = 20'((HF_START_NS * (CLK_KHZ / 1000) + 999) / 1000);
  localparam logic [19:0] MF_START_CYC = 20'((MF_START_NS * (CLK_KHZ / 1000) + 999) / 1000);
  localparam logic [19:0] LF_START_CYC = 20'((LF_START_NS * (CLK_KHZ / 1000) + 999) / 1000);
  localparam int          PLL_LOCK_CYC = PLL_LOCK_US * (CLK_KHZ / 1000);

  // ****************************************************************
  // Sources and frequency codes
  // ****************************************************************
  localparam int         NUM_OSC  = 4;
  localparam logic [2:0] SRC_LF   = 3'h0;
  localparam logic [2:0] SRC_MF   = 3'h1;
  localparam logic [2:0] SRC_HF   = 3'h2;
  localparam logic [2:0] SRC_PLL  = 3'h3;
  localparam logic [2:0] SRC_EXT  = 3'h4;

  localparam logic [15:0] SRC_HALF  [0:3] = '{LF_HALF, MF_HALF, HF_HALF, PLL_HALF};
  localparam logic [19:0] SRC_START [0:2] = '{LF_START_CYC, MF_START_CYC, HF_START_CYC};

  localparam logic [3:0] FREQ_HF_8M  = 4'he;
  localparam logic [3:0] FREQ_MF_TOP = 4'h7;
  localparam logic [3:0] FREQ_MF_LOW = 4'h3;
  localparam logic [1:0] SYSCLK_CFG  = 2'h0;
  localparam logic [1:0] CFG_INTERNAL_OSC_BLOCK  = 2'h0;

  // ****************************************************************
  // Register map and fields
  // ****************************************************************
  localparam logic [3:0] REG_CTRL      = 4'h0;
  localparam logic [3:0] REG_STAT      = 4'h1;
  localparam logic [3:0] REG_CFG       = 4'h2;
  localparam int         CTRL_SCS_LSB  = 0;
  localparam int         CTRL_FREQ_LSB = 2;
  localparam int         CTRL_SPLL_BIT = 6;
  localparam logic [7:0] CTRL_RST      = 8'h00;
  localparam logic [7:0] CTRL_MASK     = 8'h7f;
  localparam int         STAT_BUSY_BIT = 4;
  localparam int         STAT_PLL_BIT  = 5;
  localparam int         STAT_EXT_BIT  = 6;

  // ****************************************************************
  // State encodings
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_WARM   = 3'b001,
    ST_START  = 3'b010,
    ST_SWITCH = 3'b011,
    ST_UPDATE = 3'b100
  } iocs_state_e;

  typedef enum logic [1:0] {
    SW_FOLLOW = 2'b00,
    SW_FALL   = 2'b01,
    SW_HOLD   = 2'b10
  } iocs_sw_e;

endpackage : iocs_pkg

// File: hdl/iocs_glitch_switch.sv
// Glitch-free handover of the output clock level from the current to the new oscillator level.
// Assumes both levels are flop outputs on clk and that the current level keeps toggling.
`timescale 1ns/1ps
`default_nettype none

module iocs_glitch_switch
  import iocs_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Request
  input  wire logic        start,
  input  wire logic [15:0] cur_half,
  // Clock levels
  input  wire logic        cur_lvl,
  input  wire logic        new_lvl,
  // Result
  output logic             clk_out,
  output logic             busy,
  output logic             done
);

  iocs_sw_e    state_reg;
  logic        cur_prev_reg;
  logic        new_prev_reg;
  logic        new_fell_reg;
  logic [15:0] hold_cnt_reg;
  logic [15:0] half_reg;
  logic        cur_fall;
  logic        new_rise;

  assign cur_fall = cur_prev_reg & ~cur_lvl;
  assign new_rise = ~new_prev_reg & new_lvl;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_prev_reg <= 1'b0;
      new_prev_reg <= 1'b0;
    end else begin
      cur_prev_reg <= cur_lvl;
      new_prev_reg <= new_lvl;
    end
  end

  // The low gap lasts a whole low phase of the new clock and at least the old low phase,
  // so the gap is never shorter than either low phase; the first follow cycle after done still samples the old level.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg    <= SW_FOLLOW;
      clk_out      <= 1'b0;
      done         <= 1'b0;
      new_fell_reg <= 1'b0;
      hold_cnt_reg <= 16'h0000;
      half_reg     <= 16'h0000;
    end else begin
      done <= 1'b0;
      case (state_reg)
        SW_FOLLOW: begin
          clk_out <= cur_lvl;
          if (start) begin
            half_reg  <= cur_half;
            state_reg <= SW_FALL;
          end
        end
        SW_FALL: begin
          clk_out <= cur_lvl;
          if (cur_fall) begin
            state_reg    <= SW_HOLD;
            hold_cnt_reg <= 16'h0001;
            new_fell_reg <= 1'b0;
          end
        end
        SW_HOLD: begin
          clk_out <= 1'b0;
          if (hold_cnt_reg != 16'hffff) begin
            hold_cnt_reg <= hold_cnt_reg + 16'h0001;
          end
          if (new_prev_reg && !new_lvl) begin
            new_fell_reg <= 1'b1;
          end
          if (new_fell_reg && new_rise && hold_cnt_reg >= half_reg) begin
            clk_out   <= 1'b1;
            done      <= 1'b1;
            state_reg <= SW_FOLLOW;
          end
        end
        default: begin
          state_reg <= SW_FOLLOW;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
    end else begin
      busy <= (state_reg != SW_FOLLOW) || start;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence s_cur_fall;
    state_reg == SW_FALL && cur_fall;
  endsequence

  sequence s_low_held;
    !clk_out;
  endsequence

  property p_wait_fall;
    @(posedge clk) disable iff (!rst_n)
      (state_reg == SW_FALL && !cur_fall) |=> (state_reg == SW_FALL && clk_out == $past(cur_lvl));
  endproperty
  a_wait_fall: assert property (p_wait_fall) else $error("left fall wait without a falling edge");

  property p_hold_low;
    @(posedge clk) disable iff (!rst_n)
      s_cur_fall |=> s_low_held ##1 (state_reg == SW_HOLD || done);
  endproperty
  a_hold_low: assert property (p_hold_low) else $error("output not held low after old clock fell");

  property p_new_edge;
    @(posedge clk) disable iff (!rst_n)
      done |-> (clk_out && $past(new_lvl) && !$past(new_prev_reg) && $past(state_reg) == SW_HOLD);
  endproperty
  a_new_edge: assert property (p_new_edge) else $error("handover not on a new clock rising edge");

  property p_min_low;
    @(posedge clk) disable iff (!rst_n)
      done |-> ($past(hold_cnt_reg) >= half_reg && $past(new_fell_reg));
  endproperty
  a_min_low: assert property (p_min_low) else $error("low gap shorter than a source phase");

endmodule : iocs_glitch_switch

`default_nettype wire

// File: hdl/iocs_internal_osc_clock_switch.sv
// Top of the internal oscillator clock switch: register port, source selection, oscillator power,
// start-up sequencing and status. Assumes configuration straps are stable at reset release and that
// the register master follows the one-cycle strobe protocol with read data one cycle later.
//
// Summary of operation
// - Code 1110 selects 8 MHz high oscillator.
// - PLL enabled by software or config bit.
// - Config PLL forces PLL, removes plain 8 MHz.
// - No PLL while system select is 1x.
// - Sleeping new oscillator starts up first.
// - Wait for falling edge of current clock.
// - Hold low until new clock rises.
// - Update status, then mark switch complete.
// - Status shows each oscillator running state.
// - Same-source change has no start-up delay.
//
// Chosen here: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

module iocs_internal_osc_clock_switch
  import iocs_pkg::*;
#(
  parameter int PLL_LOCK_CYCLES = PLL_LOCK_CYC,
  parameter int ADDR_W          = 4
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_b,
  // Configuration word
  input  wire logic [1:0]        cfg_osc_source_sel,
  input  wire logic              cfg_pll_enable,
  // External clock level
  input  wire logic              ext_clk_level,
  // Register port
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [7:0]        reg_wr_data,
  input  wire logic              reg_wr_en,
  input  wire logic              reg_rd_en,
  output logic      [7:0]        reg_rd_data,
  // Clock and status
  output logic                   sysclk_out,
  output logic      [3:0]        osc_running,
  output logic                   switch_busy
);

  // ****************************************************************
  // Reset synchroniser and configuration capture
  // ****************************************************************
  logic rst_meta_n;
  logic rst_n;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_n <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_n      <= rst_meta_n;
    end
  end

  logic       cfg_taken_reg;
  logic [1:0] cfg_src_reg;
  logic       cfg_pll_reg;

  // Straps are caught by a clocked process once reset has released.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_taken_reg <= 1'b0;
      cfg_src_reg   <= 2'h0;
      cfg_pll_reg   <= 1'b0;
    end else if (!cfg_taken_reg) begin
      cfg_taken_reg <= 1'b1;
      cfg_src_reg   <= cfg_osc_source_sel;
      cfg_pll_reg   <= cfg_pll_enable;
    end
  end

  // ****************************************************************
  // Control register and source selection
  // ****************************************************************
  logic [7:0] osc_control_reg;
  logic [7:0] osc_status_reg;
  logic [1:0] sysclk_select;
  logic [3:0] internal_osc_block_freq_select;
  logic       sw_pll_enable;
  logic       internal_osc_block_path;
  logic       cfg_internal_osc_block_path;
  logic       pll_enabled;
  logic       pll_use;
  logic [2:0] tgt_src;
  logic [2:0] tgt_div;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_control_reg <= CTRL_RST;
    end else if (reg_wr_en && reg_addr == ADDR_W'(REG_CTRL)) begin
      osc_control_reg <= reg_wr_data & CTRL_MASK;
    end
  end

  assign sysclk_select      = osc_control_reg[CTRL_SCS_LSB +: 2];
  assign internal_osc_block_freq_select = osc_control_reg[CTRL_FREQ_LSB +: 4];
  assign sw_pll_enable      = osc_control_reg[CTRL_SPLL_BIT];

  // The internal block drives the system clock either by config choice or by forced select.
  assign cfg_internal_osc_block_path = (sysclk_select == SYSCLK_CFG) && (cfg_src_reg == CFG_INTERNAL_OSC_BLOCK);
  assign internal_osc_block_path     = sysclk_select[1] || cfg_internal_osc_block_path;
  assign pll_enabled     = sw_pll_enable || cfg_pll_reg;
  assign pll_use         = pll_enabled && cfg_internal_osc_block_path;

  // Maps the frequency code to a source and a power-of-two post divider.
  function automatic logic [5:0] iocs_map(input logic [3:0] f, input logic p);
    logic [5:0] r;
    r = {SRC_LF, 3'h0};
    if (f == FREQ_HF_8M && p) begin
      r = {SRC_PLL, 3'h0};
    end else if (f[3]) begin
      r = {SRC_HF, ~f[2:0]};
    end else if (f >= FREQ_MF_LOW) begin
      r = {SRC_MF, 3'(FREQ_MF_TOP - f)};
    end
    return r;
  endfunction : iocs_map

  always_comb begin
    if (internal_osc_block_path) begin
      {tgt_src, tgt_div} = iocs_map(internal_osc_block_freq_select, pll_use);
    end else begin
      {tgt_src, tgt_div} = {SRC_EXT, 3'h0};
    end
  end

  // ****************************************************************
  // Switch sequencer
  // ****************************************************************
  iocs_state_e state_reg;
  logic [2:0]  act_src_reg;
  logic [2:0]  act_div_reg;
  logic [2:0]  pend_src_reg;
  logic [2:0]  pend_div_reg;
  logic [4:0]  src_rdy;
  logic [4:0]  src_lvl;
  logic        sw_done;
  logic        sw_clk;
  logic        sw_busy;
  logic [15:0] cur_half;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg    <= ST_IDLE;
      act_src_reg  <= SRC_LF;
      act_div_reg  <= 3'h0;
      pend_src_reg <= SRC_LF;
      pend_div_reg <= 3'h0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (cfg_taken_reg && {tgt_src, tgt_div} != {act_src_reg, act_div_reg}) begin
            pend_src_reg <= tgt_src;
            pend_div_reg <= tgt_div;
            state_reg    <= ST_WARM;
          end
        end
        ST_WARM: begin
          // A running source passes at once; a sleeping one waits out its start-up count.
          if (src_rdy[pend_src_reg]) begin
            state_reg <= ST_START;
          end
        end
        ST_START: begin
          state_reg <= ST_SWITCH;
        end
        ST_SWITCH: begin
          if (sw_done) begin
            act_src_reg <= pend_src_reg;
            act_div_reg <= pend_div_reg;
            state_reg   <= ST_UPDATE;
          end
        end
        ST_UPDATE: begin
          state_reg <= ST_IDLE;
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Oscillators
  // ****************************************************************
  // Only the active and the pending source are powered, plus the high oscillator under the PLL.
  for (genvar g = 0; g < NUM_OSC; g++) begin : g_osc
    localparam logic [2:0]  SRC_ID  = 3'(g);
    localparam logic [19:0] START_C = (g == int'(SRC_PLL)) ? 20'(PLL_LOCK_CYCLES) : SRC_START[g % 3];
    logic        used;
    logic        en;
    logic [2:0]  div;
    logic [15:0] half;

    assign used = (act_src_reg == SRC_ID) || (state_reg != ST_IDLE && pend_src_reg == SRC_ID);
    assign div  = (state_reg != ST_IDLE && pend_src_reg == SRC_ID) ? pend_div_reg : act_div_reg;
    assign half = SRC_HALF[g] << div;
    if (g == int'(SRC_HF)) begin : g_hf
      assign en = used || g_osc[SRC_PLL].used;
    end else if (g == int'(SRC_PLL)) begin : g_pll
      assign en = used && src_rdy[SRC_HF];
    end else begin : g_plain
      assign en = used;
    end

    iocs_osc_source u_osc (
      .clk          (clk),
      .rst_n        (rst_n),
      .enable       (en),
      .half         (half),
      .start_cycles (START_C),
      .ready        (src_rdy[g]),
      .level        (src_lvl[g])
    );
  end

  assign src_rdy[SRC_EXT] = 1'b1;
  assign src_lvl[SRC_EXT] = ext_clk_level;
  assign cur_half = (act_src_reg == SRC_EXT) ? EXT_HALF : (SRC_HALF[act_src_reg[1:0]] << act_div_reg);

  iocs_glitch_switch u_switch (
    .clk      (clk),
    .rst_n    (rst_n),
    .start    (state_reg == ST_START),
    .cur_half (cur_half),
    .cur_lvl  (src_lvl[act_src_reg]),
    .new_lvl  (src_lvl[pend_src_reg]),
    .clk_out  (sw_clk),
    .busy     (sw_busy),
    .done     (sw_done)
  );

  // ****************************************************************
  // Status, outputs and read port
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_status_reg <= 8'h00;
    end else begin
      osc_status_reg[NUM_OSC-1:0]   <= src_rdy[NUM_OSC-1:0];
      osc_status_reg[STAT_BUSY_BIT] <= (state_reg != ST_IDLE) || sw_busy;
      osc_status_reg[STAT_PLL_BIT]  <= (act_src_reg == SRC_PLL);
      osc_status_reg[STAT_EXT_BIT]  <= (act_src_reg == SRC_EXT);
      osc_status_reg[7]             <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sysclk_out  <= 1'b0;
      osc_running <= 4'h0;
      switch_busy <= 1'b0;
    end else begin
      sysclk_out  <= sw_clk;
      osc_running <= osc_status_reg[NUM_OSC-1:0];
      switch_busy <= osc_status_reg[STAT_BUSY_BIT];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rd_data <= 8'h00;
    end else if (reg_rd_en) begin
      case (reg_addr)
        ADDR_W'(REG_CTRL): reg_rd_data <= osc_control_reg;
        ADDR_W'(REG_STAT): reg_rd_data <= osc_status_reg;
        ADDR_W'(REG_CFG):  reg_rd_data <= {5'h00, cfg_pll_reg, cfg_src_reg};
        default:           reg_rd_data <= 8'h00;
      endcase
    end else begin
      reg_rd_data <= 8'h00;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence s_switch_end;
    state_reg == ST_SWITCH && sw_done;
  endsequence

  property p_pll_sel;
    @(posedge clk) disable iff (!rst_n)
      (state_reg == ST_IDLE && cfg_taken_reg && cfg_internal_osc_block_path && internal_osc_block_freq_select == FREQ_HF_8M
       && pll_enabled && act_src_reg != SRC_PLL) |=> (state_reg == ST_WARM && pend_src_reg == SRC_PLL);
  endproperty
  a_pll_sel: assert property (p_pll_sel) else $error("PLL not chosen while enabled");

  property p_cfg_pll;
    @(posedge clk) disable iff (!rst_n)
      (cfg_pll_reg && cfg_internal_osc_block_path && internal_osc_block_freq_select == FREQ_HF_8M) |-> (tgt_src == SRC_PLL);
  endproperty
  a_cfg_pll: assert property (p_cfg_pll) else $error("plain 8 MHz chosen under config PLL");

  property p_no_pll_1x;
    @(posedge clk) disable iff (!rst_n)
      sysclk_select[1] |-> (tgt_src != SRC_PLL);
  endproperty
  a_no_pll_1x: assert property (p_no_pll_1x) else $error("PLL used with select 1x");

  property p_hf_8m;
    @(posedge clk) disable iff (!rst_n)
      (internal_osc_block_path && internal_osc_block_freq_select == FREQ_HF_8M && !pll_use) |-> (tgt_src == SRC_HF && tgt_div == 3'h1);
  endproperty
  a_hf_8m: assert property (p_hf_8m) else $error("code 1110 not mapped to 8 MHz");

  property p_startup;
    @(posedge clk) disable iff (!rst_n)
      (state_reg == ST_WARM && !src_rdy[pend_src_reg]) |=> (state_reg == ST_WARM);
  endproperty
  a_startup: assert property (p_startup) else $error("switch began before start-up finished");

  property p_same_src;
    @(posedge clk) disable iff (!rst_n)
      (state_reg == ST_IDLE && cfg_taken_reg && tgt_src == act_src_reg && tgt_div != act_div_reg
       && src_rdy[act_src_reg]) |=> ##1 (state_reg == ST_START);
  endproperty
  a_same_src: assert property (p_same_src) else $error("same-source change was delayed");

  property p_status_order;
    @(posedge clk) disable iff (!rst_n)
      s_switch_end |=> ##1 (osc_status_reg[STAT_PLL_BIT] == (act_src_reg == SRC_PLL)
                            && osc_status_reg[STAT_BUSY_BIT]) ##1 !osc_status_reg[STAT_BUSY_BIT];
  endproperty
  a_status_order: assert property (p_status_order) else $error("status not updated before completion");

  property p_status_run;
    @(posedge clk) disable iff (!rst_n)
      ##1 (osc_status_reg[NUM_OSC-1:0] == $past(src_rdy[NUM_OSC-1:0]));
  endproperty
  a_status_run: assert property (p_status_run) else $error("status does not follow oscillators");

endmodule : iocs_internal_osc_clock_switch

`default_nettype wire

// File: hdl/iocs_osc_source.sv
// One oscillator model: start-up count after enable, then a square level of programmable half period.
// Assumes enable and half period come from the switch controller on the same clock.
`timescale 1ns/1ps
`default_nettype none

module iocs_osc_source (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Control
  input  wire logic        enable,
  input  wire logic [15:0] half,
  input  wire logic [19:0] start_cycles,
  // State
  output logic             ready,
  output logic             level
);

  logic [19:0] start_cnt_reg;
  logic [15:0] phase_cnt_reg;

  // A powered-down oscillator loses its start-up credit and must count again.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      start_cnt_reg <= 20'h0_0000;
      ready         <= 1'b0;
    end else if (!enable) begin
      start_cnt_reg <= 20'h0_0000;
      ready         <= 1'b0;
    end else if (!ready) begin
      start_cnt_reg <= start_cnt_reg + 20'h0_0001;
      ready         <= (start_cnt_reg + 20'h0_0001 >= start_cycles);
    end
  end

  // Compare with >= so a shorter half period taking effect mid-phase ends the phase at once instead of letting the counter run past it.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_cnt_reg <= 16'h0000;
      level         <= 1'b0;
    end else if (!ready) begin
      phase_cnt_reg <= 16'h0000;
      level         <= 1'b0;
    end else if (phase_cnt_reg + 16'h0001 >= half) begin
      phase_cnt_reg <= 16'h0000;
      level         <= ~level;
    end else begin
      phase_cnt_reg <= phase_cnt_reg + 16'h0001;
    end
  end

endmodule : iocs_osc_source

`default_nettype wire

// File: testbench/tb_top.sv
// Self-checking bench for the internal oscillator clock switch: register port, source moves, status.
// Assumes the design package is compiled first; the bench drives the straps and changes them only under reset.
`timescale 1ns/1ps
`default_nettype none

module tb_top
  import iocs_pkg::*;
;
  // ****************************************************************
  // Stimulus and design
  // ****************************************************************
  logic        clk, rst_b, reg_wr_en, reg_rd_en, sysclk_out, switch_busy, cfg_pll;
  logic        ext_clk_level = 1'b0;
  logic [1:0]  cfg_src;
  logic [3:0]  reg_addr, osc_running;
  logic [7:0]  reg_wr_data, reg_rd_data, rd_val;
  logic [15:0] lf = 16'hf058;
  int          mismatches, n_checks;
  int          cyc = 0;
  logic [7:0]  ctrl_tab [0:5] = '{8'h78, 8'h7a, 8'h39, 8'h38, 8'h3c, 8'h1c};

  iocs_internal_osc_clock_switch #(.PLL_LOCK_CYCLES(20), .ADDR_W(4)) u_dut (
    .clk(clk), .rst_b(rst_b), .cfg_osc_source_sel(cfg_src), .cfg_pll_enable(cfg_pll),
    .ext_clk_level(ext_clk_level), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
    .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data),
    .sysclk_out(sysclk_out), .osc_running(osc_running), .switch_busy(switch_busy));

  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr_next

  // Expected settled state under the captured straps: {ext active, PLL, HF, MF, LF running}.
  function automatic logic [4:0] exp_src(input logic [7:0] c, input logic [1:0] s, input logic p);
    logic internal_osc_block, pll;
    internal_osc_block = c[1] || (c[1:0] == SYSCLK_CFG && s == CFG_INTERNAL_OSC_BLOCK);
    pll    = internal_osc_block && !c[1] && c[5:2] == FREQ_HF_8M && (c[6] || p);
    return {!internal_osc_block, pll, internal_osc_block && c[5], internal_osc_block && !c[5] && c[5:2] >= FREQ_MF_LOW, internal_osc_block && c[5:2] < FREQ_MF_LOW};
  endfunction : exp_src

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Random external level keeps the external source toggling.
  always @(posedge clk) begin
    lf            <= lfsr_next(lf);
    ext_clk_level <= lf[0];
    cyc           <= cyc + 1;
    if (cyc == 80000) begin
      mismatches++;
      give_verdict();
    end
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr    <= a;
    reg_wr_data <= d;
    reg_wr_en   <= 1'b1;
    @(posedge clk);
    reg_wr_en   <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_rd_en <= 1'b1;
    @(posedge clk);
    reg_rd_en <= 1'b0;
    #1 d = reg_rd_data;
    @(posedge clk);
    #1 chk(reg_rd_data, 8'h00);
  endtask : rd

  task automatic wait_switch();
    int k;
    k = 0;
    repeat (4) @(posedge clk);
    #1;
    while (switch_busy !== 1'b0 && k < 30000) begin
      @(posedge clk);
      #1;
      k++;
    end
    chk({7'h0, switch_busy}, 8'h00);
  endtask : wait_switch

  // Straps change only while reset is held, since the design captures them once after release.
  task automatic reset_dut(input logic [1:0] s, input logic p);
    @(posedge clk);
    rst_b   <= 1'b0;
    cfg_src <= s;
    cfg_pll <= p;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    repeat (8) @(posedge clk);
    wait_switch();
    rd(REG_CFG, rd_val); chk(rd_val, {5'h00, p, s});
  endtask : reset_dut

  task automatic chk_state(input logic [7:0] c);
    logic [4:0] e;
    logic [1:0] seen;
    e    = exp_src(c, cfg_src, cfg_pll);
    seen = 2'h0;
    wr(REG_CTRL, c);
    wait_switch();
    rd(REG_STAT, rd_val); chk({5'h0, rd_val[6:4]}, {5'h0, e[4:3], 1'b0});
    chk({4'h0, rd_val[3:0]}, {4'h0, e[3:0]});
    chk({4'h0, osc_running}, {4'h0, e[3:0]});
    // Long enough for both levels of the slowest source used here to show.
    repeat (600) begin
      @(posedge clk);
      #1 seen = seen | {sysclk_out, !sysclk_out};
    end
    chk({6'h0, seen}, 8'h03);
  endtask : chk_state

  task automatic give_verdict();
    if (mismatches == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : give_verdict

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    rst_b = 1'b0; reg_addr = '0; reg_wr_data = '0; reg_wr_en = 1'b0; reg_rd_en = 1'b0;
    mismatches = 0; n_checks = 0; cfg_src = 2'h0; cfg_pll = 1'b0;
    reset_dut(2'h0, 1'b0);
    rd(REG_CTRL, rd_val); chk(rd_val, CTRL_RST);
    wr(REG_CFG, 8'hff); rd(REG_CFG, rd_val); chk(rd_val, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr(4'(3 + lf % 13), lf[7:0]);
      rd(4'(3 + lf % 13), rd_val); chk(rd_val, 8'h00);
    end
    wr(REG_CTRL, 8'hff); rd(REG_CTRL, rd_val); chk(rd_val, 8'h7f);
    wait_switch();
    for (int i = 0; i < 6; i++) begin
      chk_state(ctrl_tab[i]);
    end
    // Forced PLL strap, then a non-internal source strap, each taken under a fresh reset.
    reset_dut(2'h0, 1'b1);
    chk_state(8'h38);
    chk_state(8'h3a);
    reset_dut(2'h1, 1'b0);
    chk_state(8'h38);
    give_verdict();
  end
endmodule : tb_top

`default_nettype wire
